// ===== canctl_pkg.sv
// Constants of the CAN general control, status and interrupt block.
// Assumes a single 50 MHz clock shared by the bus slave and protocol engine.
// ****************************************************************
// Operation
// - Events set object or general flags; enabled kinds also set summary bits.
// - General flags clear on writing one; writing zero keeps them.
// - Timer wrap flag clears on write one or on handler entry.
// - Own-frame form error while transmitting also raises a bit error.
// - Errors recorded per object never set general error flags.
// - Abort request clears object enables at once; ongoing transfer finishes.
// - Overload request sends an overload frame after next received frame.
// - Time-triggered mode; sync bit picks start or end of frame capture.
// - Listening mode bit and factory test bit; software keeps test clear.
// - Standby finishes transmission, freezes channel, drives recessive, stops reception.
// - Enable mode entered after 11 recessive bits; enabled flag shows mode.
// - Soft reset bit self clears, resets controller, ORed with hardware reset.
// - Overload active flag high while overload frame sent; no interrupt.
// - Transmitter and receiver busy flags reflect activity; no interrupt.
// - Bus-off and error-passive status; only entry to bus-off from error-passive interrupts.
// - Any-interrupt flag is OR of all sources except timer wrap.
// - Timer wrap flag sets when 16-bit timer rolls from FFFF to zero.
// - Frame buffer flag sets on completion; clear needs all configs rewritten.
// - General stuff, CRC, form and acknowledge error flags.
// - Global enable gates all interrupts except timer wrap; separate enable gates timer wrap.
// ****************************************************************
package canctl_pkg;
    localparam int NUM_OBJ = 6;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_GEN_FLAGS = 8'h08;
    localparam logic [7:0] OFF_GEN_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFF_OBJ_IRQ_EN = 8'h10;
    localparam logic [7:0] OFF_OBJ_SUMMARY = 8'h14;
    localparam logic [7:0] OFF_OBJ_ENABLE = 8'h18;
    localparam logic [7:0] OFF_OBJ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_TIMER = 8'h20;
    localparam logic [7:0] OFF_CAPTURE = 8'h24;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Control bits.
    localparam int CB_ABORT = 7;
    localparam int CB_OVLD = 6;
    localparam int CB_TIME_TRIG = 5;
    localparam int CB_SYNC = 4;
    localparam int CB_ONLY_MODE_A = 3;
    localparam int CB_TEST = 2;
    localparam int CB_ENABLE = 1;
    localparam int CB_SOFT_RST = 0;
    // Status bits.
    localparam int SB_OVLD = 6;
    localparam int SB_TX_BUSY = 4;
    localparam int SB_RX_BUSY = 3;
    localparam int SB_ENABLED = 2;
    localparam int SB_BUSOFF = 1;
    localparam int SB_PASSIVE = 0;
    // General flag bits.
    localparam int GB_ANY = 7;
    localparam int GB_BUSOFF = 6;
    localparam int GB_WRAP = 5;
    localparam int GB_BUF = 4;
    // General enable bits.
    localparam int EB_ALL = 7;
    localparam int EB_BUSOFF = 6;
    localparam int EB_RX = 5;
    localparam int EB_TX = 4;
    localparam int EB_ERR = 3;
    localparam int EB_BUF = 2;
    localparam int EB_GERR = 1;
    localparam int EB_WRAP = 0;
    // Object status word lanes.
    localparam int OS_RX = 0;
    localparam int OS_TX = 8;
    localparam int OS_ERR = 16;
    localparam int OS_BIT = 24;
    localparam logic [3:0] RECESSIVE_BITS = 4'hB;
endpackage

// ===== canctl_top.sv
// CAN general control, status and interrupt logic behind an AHB-Lite slave.
// Assumes the protocol engine sits on hclk and drives one-cycle event pulses;
// only the CAN receive pin arrives asynchronously.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module canctl_top
(
    input wire logic hclk, // Clock, 50 MHz.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [7:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write access.
    input wire logic [2:0] hsize, // Transfer size.
    input wire logic hready, // Bus ready in.
    input wire logic [31:0] hwdata, // Write data.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Always ready.
    output logic hresp, // Always OKAY.
    input wire logic can_rx_pin, // CAN receive pin, asynchronous.
    input wire logic bit_tick, // One pulse per CAN bit time.
    input wire logic timer_tick, // Prescaled timer increment pulse.
    input wire logic [5:0] rx_done, // Object reception complete.
    input wire logic [5:0] tx_done, // Object transmission complete.
    input wire logic [5:0] obj_error, // Error logged to object.
    input wire logic [5:0] tx_form_error, // Form error in own frame.
    input wire logic [5:0] config_written, // Object config field rewritten.
    input wire logic [5:0] buffer_set, // Objects in frame buffer set.
    input wire logic buffer_done, // Frame buffer reception complete.
    input wire logic gen_stuff_err, // Stuff error, unmatched frame.
    input wire logic gen_crc_err, // CRC error, unmatched frame.
    input wire logic gen_form_err, // Form error, unmatched frame.
    input wire logic gen_ack_err, // Acknowledge error, unmatched frame.
    input wire logic obj_matched, // Error already recorded per object.
    input wire logic overload_active, // Overload frame being sent.
    input wire logic tx_busy, // Transmitter busy.
    input wire logic rx_busy, // Receiver busy.
    input wire logic busoff_state, // Bus-off state.
    input wire logic error_passive_state, // Error-passive state.
    input wire logic sof_seen, // Start of frame pulse.
    input wire logic eof_last, // Last end-of-frame bit pulse.
    input wire logic timer_irq_ack, // Handler entry for timer wrap.
    output logic abort_request, // Abort pending communications.
    output logic overload_frame_request, // Overload frame requested.
    output logic time_triggered_mode, // Time-triggered mode.
    output logic time_trigger_sync_select, // 1: end of frame sync.
    output logic only_mode_a, // Listening mode.
    output logic test_mode, // Factory test mode.
    output logic tx_force_recessive, // Transmitter held recessive.
    output logic rx_enable, // Receiver enabled.
    output logic controller_reset, // Hardware or soft reset, high active.
    output logic irq // Interrupt request.
);
    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic [7:0] control_reg;
    logic [7:0] gen_flags_reg;
    logic [7:0] gen_irq_en_reg;
    logic [5:0] obj_irq_en_reg;
    logic [5:0] obj_enable_reg;
    logic [5:0] rx_ok_reg;
    logic [5:0] tx_ok_reg;
    logic [5:0] err_reg;
    logic [5:0] bit_err_reg;
    logic [5:0] pend_bit_reg;
    logic [5:0] rewritten_reg;
    logic [15:0] timer_reg;
    logic [15:0] capture_reg;
    logic enabled_reg;
    logic [3:0] rec_cnt_reg;
    logic busoff_prev_reg;
    logic passive_prev_reg;
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_next;
    logic [7:0] status_word;
    logic [5:0] summary;
    logic any_irq;
    logic wr;
    logic srst;
    logic [7:0] wb;
    logic acc;

    assign acc = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr = wr_pend_reg;
    assign wb = hwdata[7:0];
    // Soft reset acts for the single cycle the bit is held.
    assign srst = control_reg[canctl_pkg::CB_SOFT_RST];
    assign controller_reset = !hresetn || srst;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= canctl_pkg::RST_BYTE;
        end
        else
        begin
            wr_pend_reg <= acc && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (haddr)
            canctl_pkg::OFF_CONTROL: rdata_next[7:0] = control_reg;
            canctl_pkg::OFF_STATUS: rdata_next[7:0] = status_word;
            canctl_pkg::OFF_GEN_FLAGS: rdata_next[7:0] = gen_flags_reg | {any_irq, 7'h00};
            canctl_pkg::OFF_GEN_IRQ_EN: rdata_next[7:0] = gen_irq_en_reg;
            canctl_pkg::OFF_OBJ_IRQ_EN: rdata_next[5:0] = obj_irq_en_reg;
            canctl_pkg::OFF_OBJ_SUMMARY: rdata_next[5:0] = summary;
            canctl_pkg::OFF_OBJ_ENABLE: rdata_next[5:0] = obj_enable_reg;
            canctl_pkg::OFF_OBJ_STATUS:
            begin
                rdata_next[canctl_pkg::OS_RX +: 6] = rx_ok_reg;
                rdata_next[canctl_pkg::OS_TX +: 6] = tx_ok_reg;
                rdata_next[canctl_pkg::OS_ERR +: 6] = err_reg;
                rdata_next[canctl_pkg::OS_BIT +: 6] = bit_err_reg;
            end
            canctl_pkg::OFF_TIMER: rdata_next[15:0] = timer_reg;
            canctl_pkg::OFF_CAPTURE: rdata_next[15:0] = capture_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (acc && !hwrite)
            hrdata <= rdata_next;
    end

    // ****************************************************************
    // Control and enables
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            control_reg <= canctl_pkg::RST_BYTE;
        else if (wr && wr_addr_reg == canctl_pkg::OFF_CONTROL)
            control_reg <= wb;
        else
            control_reg[canctl_pkg::CB_SOFT_RST] <= 1'b0;
    end

    assign abort_request = control_reg[canctl_pkg::CB_ABORT];
    assign overload_frame_request = control_reg[canctl_pkg::CB_OVLD];
    assign time_triggered_mode = control_reg[canctl_pkg::CB_TIME_TRIG];
    assign time_trigger_sync_select = control_reg[canctl_pkg::CB_SYNC];
    assign only_mode_a = control_reg[canctl_pkg::CB_ONLY_MODE_A];
    assign test_mode = control_reg[canctl_pkg::CB_TEST];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gen_irq_en_reg <= canctl_pkg::RST_BYTE;
            obj_irq_en_reg <= 6'h00;
        end
        else if (srst)
        begin
            gen_irq_en_reg <= canctl_pkg::RST_BYTE;
            obj_irq_en_reg <= 6'h00;
        end
        else if (wr && wr_addr_reg == canctl_pkg::OFF_GEN_IRQ_EN)
            gen_irq_en_reg <= wb;
        else if (wr && wr_addr_reg == canctl_pkg::OFF_OBJ_IRQ_EN)
            obj_irq_en_reg <= wb[5:0];
    end

    // Objects become enabled when their configuration is written and drop
    // out on completion, abort or standby; configurations are left alone.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            obj_enable_reg <= 6'h00;
        else if (srst || abort_request || !enabled_reg)
            obj_enable_reg <= 6'h00;
        else
            obj_enable_reg <= (obj_enable_reg | config_written) & ~(rx_done | tx_done);
    end

    // ****************************************************************
    // Enable and standby sequencing
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= can_rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Standby waits for the transmitter to go idle so a frame is never cut.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enabled_reg <= 1'b0;
            rec_cnt_reg <= 4'h0;
        end
        else if (srst)
        begin
            enabled_reg <= 1'b0;
            rec_cnt_reg <= 4'h0;
        end
        else if (!control_reg[canctl_pkg::CB_ENABLE])
        begin
            rec_cnt_reg <= 4'h0;
            if (!tx_busy)
                enabled_reg <= 1'b0;
        end
        else if (!enabled_reg && bit_tick)
        begin
            if (!rx_sync_reg)
                rec_cnt_reg <= 4'h0;
            else if (rec_cnt_reg == canctl_pkg::RECESSIVE_BITS - 4'h1)
                enabled_reg <= 1'b1;
            else
                rec_cnt_reg <= rec_cnt_reg + 4'h1;
        end
    end

    assign tx_force_recessive = !enabled_reg;
    assign rx_enable = enabled_reg;

    assign status_word = {1'b0, overload_active, 1'b0, tx_busy, rx_busy,
                          enabled_reg, busoff_state, error_passive_state};

    // ****************************************************************
    // Timer and time-trigger capture
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_reg <= 16'h0000;
            capture_reg <= 16'h0000;
        end
        else if (srst || !enabled_reg)
            timer_reg <= 16'h0000;
        else
        begin
            if (timer_tick)
                timer_reg <= timer_reg + 16'h0001;
            if (time_triggered_mode && (time_trigger_sync_select ? eof_last : sof_seen))
                capture_reg <= timer_reg;
        end
    end

    // ****************************************************************
    // Object flags
    // ****************************************************************
    // Software writes zero to clear and one to keep; a same-cycle event wins.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_ok_reg <= 6'h00;
            tx_ok_reg <= 6'h00;
            err_reg <= 6'h00;
            bit_err_reg <= 6'h00;
            pend_bit_reg <= 6'h00;
        end
        else if (srst)
        begin
            rx_ok_reg <= 6'h00;
            tx_ok_reg <= 6'h00;
            err_reg <= 6'h00;
            bit_err_reg <= 6'h00;
            pend_bit_reg <= 6'h00;
        end
        else
        begin
            // The follow-on bit error lands one cycle later as its own event.
            pend_bit_reg <= tx_form_error;
            if (wr && wr_addr_reg == canctl_pkg::OFF_OBJ_STATUS)
            begin
                rx_ok_reg <= (rx_ok_reg & hwdata[canctl_pkg::OS_RX +: 6]) | rx_done;
                tx_ok_reg <= (tx_ok_reg & hwdata[canctl_pkg::OS_TX +: 6]) | tx_done;
                err_reg <= (err_reg & hwdata[canctl_pkg::OS_ERR +: 6]) | obj_error | tx_form_error;
                bit_err_reg <= (bit_err_reg & hwdata[canctl_pkg::OS_BIT +: 6]) | pend_bit_reg;
            end
            else
            begin
                rx_ok_reg <= rx_ok_reg | rx_done;
                tx_ok_reg <= tx_ok_reg | tx_done;
                err_reg <= err_reg | obj_error | tx_form_error;
                bit_err_reg <= bit_err_reg | pend_bit_reg;
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < canctl_pkg::NUM_OBJ; i++)
        begin
            summary[i] = obj_irq_en_reg[i] &&
                ((rx_ok_reg[i] && gen_irq_en_reg[canctl_pkg::EB_RX]) ||
                 (tx_ok_reg[i] && gen_irq_en_reg[canctl_pkg::EB_TX]) ||
                 ((err_reg[i] || bit_err_reg[i]) && gen_irq_en_reg[canctl_pkg::EB_ERR]));
        end
    end

    // ****************************************************************
    // General flags
    // ****************************************************************
    logic [7:0] gen_set;
    logic [7:0] gen_clr;
    logic bx_clear_ok;

    assign bx_clear_ok = (buffer_set & ~rewritten_reg) == 6'h00;

    always_comb
    begin
        gen_set = 8'h00;
        gen_set[canctl_pkg::GB_BUSOFF] = busoff_state && !busoff_prev_reg && passive_prev_reg;
        gen_set[canctl_pkg::GB_WRAP] = timer_tick && enabled_reg && timer_reg == 16'hFFFF;
        gen_set[canctl_pkg::GB_BUF] = buffer_done;
        gen_set[3:0] = {gen_stuff_err, gen_crc_err, gen_form_err, gen_ack_err}
                       & {4{!obj_matched}};
        gen_clr = 8'h00;
        if (wr && wr_addr_reg == canctl_pkg::OFF_GEN_FLAGS)
            gen_clr = {1'b0, wb[6:0]};
        if (!bx_clear_ok)
            gen_clr[canctl_pkg::GB_BUF] = 1'b0;
        if (timer_irq_ack)
            gen_clr[canctl_pkg::GB_WRAP] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gen_flags_reg <= canctl_pkg::RST_BYTE;
            busoff_prev_reg <= 1'b0;
            passive_prev_reg <= 1'b0;
            rewritten_reg <= 6'h00;
        end
        else if (srst)
        begin
            gen_flags_reg <= canctl_pkg::RST_BYTE;
            busoff_prev_reg <= 1'b0;
            passive_prev_reg <= 1'b0;
            rewritten_reg <= 6'h00;
        end
        else
        begin
            busoff_prev_reg <= busoff_state;
            passive_prev_reg <= error_passive_state;
            // Set wins over a clear in the same cycle.
            gen_flags_reg <= (gen_flags_reg & ~gen_clr) | gen_set;
            if (buffer_done)
                rewritten_reg <= 6'h00;
            else
                rewritten_reg <= rewritten_reg | config_written;
        end
    end

    // ****************************************************************
    // Interrupt request
    // ****************************************************************
    assign any_irq = (summary != 6'h00) ||
        (gen_flags_reg[canctl_pkg::GB_BUSOFF] && gen_irq_en_reg[canctl_pkg::EB_BUSOFF]) ||
        (gen_flags_reg[canctl_pkg::GB_BUF] && gen_irq_en_reg[canctl_pkg::EB_BUF]) ||
        ((gen_flags_reg[3:0] != 4'h0) && gen_irq_en_reg[canctl_pkg::EB_GERR]);

    assign irq = (any_irq && gen_irq_en_reg[canctl_pkg::EB_ALL]) ||
        (gen_flags_reg[canctl_pkg::GB_WRAP] && gen_irq_en_reg[canctl_pkg::EB_WRAP]);
endmodule

// ===== canctl_bus_model.sv
// Behavioural model of the CAN bus as the controller's receiver sees it.
// Assumes one system clock; the bus idles recessive through its pull-up.
`timescale 1ns/1ps
module canctl_bus_model
(
    input wire logic hclk, // System clock.
    input wire logic hresetn, // Reset, active low.
    input wire logic dominant, // Pull the bus dominant.
    output logic can_rx_pin, // Bus level, 1 is recessive.
    output logic bit_tick // One pulse per bit time.
);
    // ****
    // Bit timing
    // ****
    logic [1:0] div_reg;
    // An idle bus reads recessive, so enabling can count it.
    assign can_rx_pin = !dominant;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_reg <= 2'h0;
            bit_tick <= 1'b0;
        end
        else
        begin
            div_reg <= div_reg + 2'h1;
            bit_tick <= div_reg == 2'h3;
        end
    end
endmodule

// ===== canctl_top_properties.sv
// Concurrent checks on the ports of the CAN general control block.
// Assumes a zero-wait bus slave clocked by hclk.
`timescale 1ns/1ps
module canctl_top_properties
(
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hwdata, hrdata,
    input wire logic bit_tick, tx_busy, timer_irq_ack, irq, controller_reset,
    input wire logic abort_request, overload_frame_request, time_triggered_mode,
    input wire logic time_trigger_sync_select, only_mode_a, test_mode,
    input wire logic tx_force_recessive, rx_enable
);
    // ****
    // Checks
    // ****
    logic take, wr_q, rd_q, ctl_q;
    logic [5:0] mode;
    assign take = hsel && hready && htrans[1];
    assign mode = {abort_request, overload_frame_request, time_triggered_mode,
        time_trigger_sync_select, only_mode_a, test_mode};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ctl_q <= 1'b0;
        end
        else
        begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            ctl_q <= take && hwrite && haddr == 8'h00;
        end
    end
    default clocking dclk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    okay_resp_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not okay");
    ctl_mirror_a: assert property (ctl_q |=> mode == $past(hwdata[7:2]))
        else $error("control outputs differ from written byte");
    soft_reset_a: assert property (ctl_q && hwdata[0] |=> controller_reset ##1 !controller_reset)
        else $error("soft reset is not a single cycle");
    recessive_a: assert property (tx_force_recessive == !rx_enable)
        else $error("transmitter not recessive while disabled");
    enable_tick_a: assert property ($rose(rx_enable) |-> $past(bit_tick))
        else $error("enabled away from a bit time");
    standby_wait_a: assert property ($fell(rx_enable) && !$past(controller_reset) |-> !$past(tx_busy))
        else $error("standby cut a transmission short");
    irq_hold_a: assert property (irq && !wr_q && !timer_irq_ack && !controller_reset |=> irq)
        else $error("interrupt dropped without a clear");
    read_hold_a: assert property (!rd_q && !$past(controller_reset) |-> $stable(hrdata))
        else $error("read data moved outside a read");
    cover property ($rose(rx_enable));
    cover property (controller_reset && hresetn);
    cover property ($fell(irq));
endmodule
bind canctl_top canctl_top_properties canctl_top_properties_i (.*);

// ===== can_general_control_and_interrupts_test.sv
// Self-checking bench for the CAN general control, status and interrupt block.
// Assumes the bus model file and the checker are compiled alongside.
`timescale 1ns/1ps
module can_general_control_and_interrupts_test;
    // ****
    // Stimulus and checks
    // ****
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic can_rx_pin, bit_tick, timer_tick = 0, buffer_done = 0, dominant = 0;
    logic [5:0] rx_done = 0, tx_done = 0, obj_error = 0, tx_form_error = 0;
    logic [5:0] config_written = 0, buffer_set = 0, mode;
    logic gen_stuff_err = 0, gen_crc_err = 0, gen_form_err = 0, gen_ack_err = 0;
    logic obj_matched = 0, overload_active = 0, tx_busy = 0, rx_busy = 0;
    logic busoff_state = 0, error_passive_state = 0, sof_seen = 0, eof_last = 0;
    logic timer_irq_ack = 0, abort_request, overload_frame_request, time_triggered_mode;
    logic time_trigger_sync_select, only_mode_a, test_mode, tx_force_recessive;
    logic rx_enable, controller_reset, irq;
    int bad_count = 0, check_count = 0;
    assign hready = hreadyout;
    assign mode = {abort_request, overload_frame_request, time_triggered_mode,
        time_trigger_sync_select, only_mode_a, test_mode};
    canctl_top canctl_top_i (.*);
    canctl_bus_model canctl_bus_model_i (.*);
    initial
        forever #10 hclk = ~hclk;
    task automatic tk(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do tk(1); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do tk(1); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    task automatic gpulse(input logic [3:0] v);
        {gen_stuff_err, gen_crc_err, gen_form_err, gen_ack_err} <= v;
        tk(1);
        {gen_stuff_err, gen_crc_err, gen_form_err, gen_ack_err} <= 4'h0;
    endtask
    task automatic t_reset;
        rdchk(8'h00, 32'h0, "control");
        xfer(1'b1, 8'h04, 32'hFF);
        rdchk(8'h04, 32'h0, "status");
        xfer(1'b1, 8'h3C, 32'hFF);
        rdchk(8'h3C, 32'h0, "unmapped");
    endtask
    task automatic t_ctrl;
        for (int b = 3; b < 8; b++)
        begin
            xfer(1'b1, 8'h00, 32'h1 << b);
            tk(1);
            chk({26'h0, mode}, 32'h1 << (b - 2), "mode");
        end
        xfer(1'b1, 8'h00, 32'h0);
    endtask
    task automatic t_gen;
        xfer(1'b1, 8'h0C, 32'h82);
        gpulse(4'hF);
        rdchk(8'h08, 32'h8F, "general errors");
        chk(irq, 1'b1, "irq on");
        xfer(1'b1, 8'h08, 32'h05);
        rdchk(8'h08, 32'h8A, "write one");
        xfer(1'b1, 8'h08, 32'h0A);
        rdchk(8'h08, 32'h0, "all clear");
        chk(irq, 1'b0, "irq off");
        obj_matched <= 1'b1;
        gpulse(4'hF);
        obj_matched <= 1'b0;
        rdchk(8'h08, 32'h0, "matched");
    endtask
    task automatic t_enable;
        xfer(1'b1, 8'h00, 32'h02);
        repeat (10) do tk(1); while (bit_tick !== 1'b1);
        chk(rx_enable, 1'b0, "early enable");
        do tk(1); while (bit_tick !== 1'b1);
        tk(1);
        chk(rx_enable, 1'b1, "enable");
        rdchk(8'h04, 32'h04, "enabled flag");
    endtask
    task automatic t_timer;
        xfer(1'b1, 8'h0C, 32'h01);
        timer_tick <= 1'b1;
        tk(65535);
        chk(irq, 1'b0, "no wrap");
        tk(1);
        timer_tick <= 1'b0;
        tk(1);
        chk(irq, 1'b1, "wrap");
        rdchk(8'h08, 32'h20, "wrap flag");
        xfer(1'b1, 8'h0C, 32'h0);
        tk(1);
        chk(irq, 1'b0, "gated");
        xfer(1'b1, 8'h0C, 32'h01);
        timer_irq_ack <= 1'b1;
        tk(1);
        timer_irq_ack <= 1'b0;
        tk(1);
        chk(irq, 1'b0, "handler");
    endtask
    task automatic t_obj;
        xfer(1'b1, 8'h10, 32'h03);
        xfer(1'b1, 8'h0C, 32'hB8);
        rx_done <= 6'h01;
        tx_form_error <= 6'h02;
        tk(1);
        rx_done <= 6'h00;
        tx_form_error <= 6'h00;
        tk(2);
        rdchk(8'h14, 32'h03, "summary");
        rdchk(8'h1C, 32'h0202_0001, "object status");
        xfer(1'b1, 8'h1C, rd & 32'h0202_0000);
        rdchk(8'h1C, 32'h0202_0000, "rmw clear");
        xfer(1'b1, 8'h1C, 32'h0);
        rdchk(8'h14, 32'h0, "summary clear");
    endtask
    task automatic t_status;
        {overload_active, tx_busy, rx_busy, error_passive_state} <= 4'hF;
        xfer(1'b1, 8'h0C, 32'hC0);
        busoff_state <= 1'b1;
        tk(2);
        rdchk(8'h04, 32'h5F, "status bits");
        rdchk(8'h08, 32'hC0, "bus-off flag");
        xfer(1'b1, 8'h08, 32'h40);
        {busoff_state, error_passive_state, overload_active, rx_busy} <= 4'h0;
        tk(1);
        busoff_state <= 1'b1;
        tk(2);
        rdchk(8'h08, 32'h0, "no passive");
    endtask
    task automatic t_buffer;
        buffer_set <= 6'h03;
        buffer_done <= 1'b1;
        tk(1);
        buffer_done <= 1'b0;
        config_written <= 6'h01;
        tk(1);
        config_written <= 6'h00;
        xfer(1'b1, 8'h08, 32'h10);
        rdchk(8'h08, 32'h10, "buffer kept");
        config_written <= 6'h02;
        tk(1);
        config_written <= 6'h00;
        xfer(1'b1, 8'h08, 32'h10);
        rdchk(8'h08, 32'h0, "buffer clear");
    endtask
    task automatic t_standby;
        xfer(1'b1, 8'h00, 32'h82);
        xfer(1'b1, 8'h00, 32'h80);
        rdchk(8'h18, 32'h0, "abort");
        tk(3);
        chk(rx_enable, 1'b1, "held by transmit");
        tx_busy <= 1'b0;
        tk(2);
        chk({rx_enable, tx_force_recessive}, 2'b01, "standby");
    endtask
    task automatic t_soft_reset_request;
        gpulse(4'h1);
        xfer(1'b1, 8'h00, 32'h21);
        tk(3);
        rdchk(8'h08, 32'h0, "flags reset");
        rdchk(8'h00, 32'h20, "self clear");
    endtask
    task automatic finish_test;
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        tk(8);
        hresetn <= 1'b1;
        tk(1);
        t_reset;
        t_ctrl;
        t_gen;
        t_enable;
        t_timer;
        t_obj;
        t_status;
        t_buffer;
        t_standby;
        t_soft_reset_request;
        finish_test;
    end
    initial
    begin
        tk(90000);
        bad_count++;
        finish_test;
    end
endmodule
